// File: hw/gpio_bank_pkg.sv
package gpio_bank_pkg;

  // pin counts and bank layout
  localparam int PIN_COUNT = 58;
  localparam int BANK_W = 32;
  localparam int FSEL_W = 3;
  localparam int FSEL_PER_WORD = 10;
  localparam int FSEL_WORDS = 6;
  localparam int ADDR_W = 8;

  // register byte offsets
  localparam logic [7:0] FSEL_FIRST = 8'h00;
  localparam logic [7:0] FSEL_LAST = 8'h14;
  localparam logic [7:0] DRIVE_HIGH0 = 8'h1c;
  localparam logic [7:0] DRIVE_HIGH1 = 8'h20;
  localparam logic [7:0] DRIVE_LOW0 = 8'h28;
  localparam logic [7:0] DRIVE_LOW1 = 8'h2c;
  localparam logic [7:0] LEVEL0 = 8'h34;
  localparam logic [7:0] LEVEL1 = 8'h38;
  localparam logic [7:0] STATUS0 = 8'h40;
  localparam logic [7:0] STATUS1 = 8'h44;
  localparam logic [7:0] RISE_EN0 = 8'h4c;
  localparam logic [7:0] RISE_EN1 = 8'h50;
  localparam logic [7:0] FALL_EN0 = 8'h58;
  localparam logic [7:0] FALL_EN1 = 8'h5c;
  localparam logic [7:0] HIGH_EN0 = 8'h64;
  localparam logic [7:0] HIGH_EN1 = 8'h68;
  localparam logic [7:0] LOW_EN0 = 8'h70;
  localparam logic [7:0] LOW_EN1 = 8'h74;
  localparam logic [7:0] IRQ_EN0 = 8'h80;
  localparam logic [7:0] IRQ_EN1 = 8'h84;
  localparam logic [7:0] IRQ_CLR0 = 8'h88;
  localparam logic [7:0] IRQ_CLR1 = 8'h8c;

  // field masks and reset values
  localparam logic [31:0] FSEL_MASK = 32'h3fff_ffff;
  localparam logic [31:0] FSEL_LAST_MASK = 32'h00ff_ffff;
  localparam logic [57:0] PINS_ZERO = 58'h000_0000_0000_0000;
  localparam logic [57:0] IRQ_EN_RESET = 58'h3ff_ffff_ffff_ffff;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // function selector codes
  localparam logic [2:0] FUNC_INPUT = 3'h0;
  localparam logic [2:0] FUNC_OUTPUT = 3'h1;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : gpio_bank_pkg

// File: hw/gpio_output_level_event_bank.sv
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

module gpio_output_level_event_bank (
  input wire logic aclk, // system clock, 50 MHz
  input wire logic aresetn, // synchronous reset, active low
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic [7:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [7:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic [57:0] pin_in, // pin levels from the pads
  output logic [57:0] pin_out, // pin output values
  output logic [57:0] pin_oe, // pin output enables
  output logic irq_bank0, // any enabled flag in bank 0
  output logic irq_bank1, // any enabled flag in bank 1
  output logic irq_any // any enabled flag at all
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // place a 32-bit bank word at its pin positions
  function automatic logic [57:0] spread(input logic bank, input logic [31:0] v);
    logic [63:0] w;
    w = 64'h0000_0000_0000_0000;
    if (bank)
    begin
      w[63:32] = v;
    end
    else
    begin
      w[31:0] = v;
    end
    return w[57:0];
  endfunction : spread

  // pick a bank word out of a pin vector; bank 1 upper bits read zero
  function automatic logic [31:0] pick(input logic bank, input logic [57:0] v);
    logic [63:0] w;
    w = {6'h00, v};
    return bank ? w[63:32] : w[31:0];
  endfunction : pick

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling

  logic [57:0] sync1_reg, sync2_reg, hist1_reg, hist2_reg;
  logic [57:0] sync1_next, sync2_next, hist1_next, hist2_next;
  logic [57:0] rise_seen, fall_seen;

  // the first stage is only read by the second, so metastability stays put
  always_comb
  begin
    sync1_next = pin_in;
    sync2_next = sync1_reg;
    hist1_next = sync2_reg;
    hist2_next = hist1_reg;
    // oldest sample first; needing two equal new samples drops one-cycle glitches
    rise_seen = ~hist2_reg & hist1_reg & sync2_reg;
    fall_seen = hist2_reg & ~hist1_reg & ~sync2_reg;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_reg <= gpio_bank_pkg::PINS_ZERO;
      sync2_reg <= gpio_bank_pkg::PINS_ZERO;
      hist1_reg <= gpio_bank_pkg::PINS_ZERO;
      hist2_reg <= gpio_bank_pkg::PINS_ZERO;
    end
    else if (ce)
    begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      hist1_reg <= hist1_next;
      hist2_reg <= hist2_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus write and read channels

  logic aw_have_reg, w_have_reg, bvalid_reg, awready_reg, wready_reg;
  logic aw_have_next, w_have_next, bvalid_next, awready_next, wready_next;
  logic [7:0] aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic arready_reg, rvalid_reg, arready_next, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic do_write, wr_hit, rd_hit;
  logic [31:0] wmask, wones, rd_word;

  // address and data are taken in either order; the write happens once both are held
  always_comb
  begin
    aw_have_next = aw_have_reg | (awvalid & awready_reg);
    w_have_next = w_have_reg | (wvalid & wready_reg);
    aw_addr_next = (awvalid & awready_reg) ? awaddr : aw_addr_reg;
    w_data_next = (wvalid & wready_reg) ? wdata : w_data_reg;
    w_strb_next = (wvalid & wready_reg) ? wstrb : w_strb_reg;
    bvalid_next = bvalid_reg & ~bready;
    bresp_next = bresp_reg;
    do_write = aw_have_reg & w_have_reg & ~bvalid_reg;
    if (do_write)
    begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = wr_hit ? gpio_bank_pkg::RESP_OKAY : gpio_bank_pkg::RESP_SLVERR;
    end
    // ready drops while a word is held or a response waits
    awready_next = ~aw_have_next & ~bvalid_next & ~do_write;
    wready_next = ~w_have_next & ~bvalid_next & ~do_write;
    // one read at a time, data one cycle after the address is taken
    rvalid_next = rvalid_reg & ~rready;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (arvalid & arready_reg)
    begin
      rvalid_next = 1'b1;
      rdata_next = rd_hit ? rd_word : gpio_bank_pkg::WORD_ZERO;
      rresp_next = rd_hit ? gpio_bank_pkg::RESP_OKAY : gpio_bank_pkg::RESP_SLVERR;
    end
    arready_next = ~rvalid_next;
    wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
    wones = w_data_reg & wmask;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= gpio_bank_pkg::WORD_ZERO;
      w_strb_reg <= 4'h0;
      bresp_reg <= gpio_bank_pkg::RESP_OKAY;
      rresp_reg <= gpio_bank_pkg::RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= gpio_bank_pkg::WORD_ZERO;
    end
    else if (ce)
    begin
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      bvalid_reg <= bvalid_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      aw_addr_reg <= aw_addr_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bresp_reg <= bresp_next;
      rresp_reg <= rresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration, output latch and event flags

  logic [31:0] fsel_reg [6];
  logic [31:0] fsel_next [6];
  logic [57:0] out_val_reg, oe_reg, rise_en_reg, fall_en_reg, high_en_reg, low_en_reg;
  logic [57:0] out_val_next, oe_next, rise_en_next, fall_en_next, high_en_next, low_en_next;
  logic [57:0] status_reg, ien_reg, status_next, ien_next;
  logic [57:0] set_pulse, clr_pulse, ack_pulse, event_set, merge_m, merge_v;
  logic irq0_reg, irq1_reg, irqa_reg, irq0_next, irq1_next, irqa_next;
  logic bank;
  logic [2:0] fidx;
  logic [31:0] fmask;

  // register writes, event capture and interrupt lines
  always_comb
  begin
    for (int i = 0; i < gpio_bank_pkg::FSEL_WORDS; i++)
    begin
      fsel_next[i] = fsel_reg[i];
    end
    rise_en_next = rise_en_reg;
    fall_en_next = fall_en_reg;
    high_en_next = high_en_reg;
    low_en_next = low_en_reg;
    ien_next = ien_reg;
    set_pulse = gpio_bank_pkg::PINS_ZERO;
    clr_pulse = gpio_bank_pkg::PINS_ZERO;
    ack_pulse = gpio_bank_pkg::PINS_ZERO;
    wr_hit = 1'b1;
    bank = aw_addr_reg[2];
    fidx = aw_addr_reg[4:2];
    fmask = (fidx == 3'h5) ? gpio_bank_pkg::FSEL_LAST_MASK : gpio_bank_pkg::FSEL_MASK;
    merge_m = spread(bank, wmask);
    merge_v = spread(bank, w_data_reg);
    if (aw_addr_reg[1:0] != 2'h0)
    begin
      wr_hit = 1'b0;
    end
    else if (aw_addr_reg <= gpio_bank_pkg::FSEL_LAST)
    begin
      if (do_write)
      begin
        fsel_next[fidx] = (fsel_reg[fidx] & ~(wmask & fmask)) | (w_data_reg & wmask & fmask);
      end
    end
    else if (aw_addr_reg == gpio_bank_pkg::DRIVE_HIGH0 || aw_addr_reg == gpio_bank_pkg::DRIVE_HIGH1)
    begin
      bank = (aw_addr_reg == gpio_bank_pkg::DRIVE_HIGH1);
      set_pulse = do_write ? spread(bank, wones) : gpio_bank_pkg::PINS_ZERO;
    end
    else if (aw_addr_reg == gpio_bank_pkg::DRIVE_LOW0 || aw_addr_reg == gpio_bank_pkg::DRIVE_LOW1)
    begin
      bank = (aw_addr_reg == gpio_bank_pkg::DRIVE_LOW1);
      clr_pulse = do_write ? spread(bank, wones) : gpio_bank_pkg::PINS_ZERO;
    end
    else if (aw_addr_reg == gpio_bank_pkg::LEVEL0 || aw_addr_reg == gpio_bank_pkg::LEVEL1)
    begin
      wr_hit = 1'b1;
    end
    else if (aw_addr_reg == gpio_bank_pkg::STATUS0 || aw_addr_reg == gpio_bank_pkg::STATUS1
             || aw_addr_reg == gpio_bank_pkg::IRQ_CLR0 || aw_addr_reg == gpio_bank_pkg::IRQ_CLR1)
    begin
      ack_pulse = do_write ? spread(bank, wones) : gpio_bank_pkg::PINS_ZERO;
    end
    else if (aw_addr_reg == gpio_bank_pkg::RISE_EN0 || aw_addr_reg == gpio_bank_pkg::RISE_EN1)
    begin
      bank = (aw_addr_reg == gpio_bank_pkg::RISE_EN1);
      if (do_write)
      begin
        rise_en_next = (rise_en_reg & ~spread(bank, wmask)) | spread(bank, wones);
      end
    end
    else if (aw_addr_reg == gpio_bank_pkg::FALL_EN0 || aw_addr_reg == gpio_bank_pkg::FALL_EN1)
    begin
      bank = (aw_addr_reg == gpio_bank_pkg::FALL_EN1);
      if (do_write)
      begin
        fall_en_next = (fall_en_reg & ~spread(bank, wmask)) | spread(bank, wones);
      end
    end
    else if (aw_addr_reg == gpio_bank_pkg::HIGH_EN0 || aw_addr_reg == gpio_bank_pkg::HIGH_EN1)
    begin
      bank = (aw_addr_reg == gpio_bank_pkg::HIGH_EN1);
      if (do_write)
      begin
        high_en_next = (high_en_reg & ~spread(bank, wmask)) | spread(bank, wones);
      end
    end
    else if (aw_addr_reg == gpio_bank_pkg::LOW_EN0 || aw_addr_reg == gpio_bank_pkg::LOW_EN1)
    begin
      if (do_write)
      begin
        low_en_next = (low_en_reg & ~merge_m) | (merge_v & merge_m);
      end
    end
    else if (aw_addr_reg == gpio_bank_pkg::IRQ_EN0 || aw_addr_reg == gpio_bank_pkg::IRQ_EN1)
    begin
      if (do_write)
      begin
        ien_next = (ien_reg & ~merge_m) | (merge_v & merge_m);
      end
    end
    else
    begin
      wr_hit = 1'b0;
    end
    // the latch follows every drive write even on input pins
    out_val_next = (out_val_reg | set_pulse) & ~clr_pulse;
    // only code 001 drives the pad; input and alternates release it
    for (int p = 0; p < gpio_bank_pkg::PIN_COUNT; p++)
    begin
      oe_next[p] = (fsel_next[p / 10][(p % 10) * 3 +: 3] == gpio_bank_pkg::FUNC_OUTPUT);
    end
    event_set = (rise_en_reg & rise_seen)
      | (fall_en_reg & fall_seen)
      | (high_en_reg & sync2_reg)
      | (low_en_reg & ~sync2_reg);
    // set term last so an event in the clearing cycle survives
    status_next = (status_reg & ~ack_pulse) | event_set;
    irq0_next = |(status_next[31:0] & ien_next[31:0]);
    irq1_next = |(status_next[57:32] & ien_next[57:32]);
    irqa_next = |(status_next & ien_next);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < gpio_bank_pkg::FSEL_WORDS; i++)
      begin
        fsel_reg[i] <= gpio_bank_pkg::WORD_ZERO;
      end
      out_val_reg <= gpio_bank_pkg::PINS_ZERO;
      oe_reg <= gpio_bank_pkg::PINS_ZERO;
      rise_en_reg <= gpio_bank_pkg::PINS_ZERO;
      fall_en_reg <= gpio_bank_pkg::PINS_ZERO;
      high_en_reg <= gpio_bank_pkg::PINS_ZERO;
      low_en_reg <= gpio_bank_pkg::PINS_ZERO;
      status_reg <= gpio_bank_pkg::PINS_ZERO;
      ien_reg <= gpio_bank_pkg::IRQ_EN_RESET;
      irq0_reg <= 1'b0;
      irq1_reg <= 1'b0;
      irqa_reg <= 1'b0;
    end
    else if (ce)
    begin
      fsel_reg <= fsel_next;
      out_val_reg <= out_val_next;
      oe_reg <= oe_next;
      rise_en_reg <= rise_en_next;
      fall_en_reg <= fall_en_next;
      high_en_reg <= high_en_next;
      low_en_reg <= low_en_next;
      status_reg <= status_next;
      ien_reg <= ien_next;
      irq0_reg <= irq0_next;
      irq1_reg <= irq1_next;
      irqa_reg <= irqa_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read decode

  logic rbank;

  // write-only drive registers read as zero
  always_comb
  begin
    rd_hit = 1'b1;
    rd_word = gpio_bank_pkg::WORD_ZERO;
    rbank = araddr[2];
    if (araddr[1:0] != 2'h0)
    begin
      rd_hit = 1'b0;
    end
    else if (araddr <= gpio_bank_pkg::FSEL_LAST)
    begin
      rd_word = fsel_reg[araddr[4:2]];
    end
    else if (araddr == gpio_bank_pkg::DRIVE_HIGH0 || araddr == gpio_bank_pkg::DRIVE_HIGH1
             || araddr == gpio_bank_pkg::DRIVE_LOW0 || araddr == gpio_bank_pkg::DRIVE_LOW1
             || araddr == gpio_bank_pkg::IRQ_CLR0 || araddr == gpio_bank_pkg::IRQ_CLR1)
    begin
      rd_word = gpio_bank_pkg::WORD_ZERO;
    end
    else if (araddr == gpio_bank_pkg::LEVEL0 || araddr == gpio_bank_pkg::LEVEL1)
    begin
      rd_word = pick(araddr == gpio_bank_pkg::LEVEL1, sync2_reg);
    end
    else if (araddr == gpio_bank_pkg::STATUS0 || araddr == gpio_bank_pkg::STATUS1)
    begin
      rd_word = pick(rbank, status_reg);
    end
    else if (araddr == gpio_bank_pkg::RISE_EN0 || araddr == gpio_bank_pkg::RISE_EN1)
    begin
      rd_word = pick(araddr == gpio_bank_pkg::RISE_EN1, rise_en_reg);
    end
    else if (araddr == gpio_bank_pkg::FALL_EN0 || araddr == gpio_bank_pkg::FALL_EN1)
    begin
      rd_word = pick(araddr == gpio_bank_pkg::FALL_EN1, fall_en_reg);
    end
    else if (araddr == gpio_bank_pkg::HIGH_EN0 || araddr == gpio_bank_pkg::HIGH_EN1)
    begin
      rd_word = pick(araddr == gpio_bank_pkg::HIGH_EN1, high_en_reg);
    end
    else if (araddr == gpio_bank_pkg::LOW_EN0 || araddr == gpio_bank_pkg::LOW_EN1)
    begin
      rd_word = pick(rbank, low_en_reg);
    end
    else if (araddr == gpio_bank_pkg::IRQ_EN0 || araddr == gpio_bank_pkg::IRQ_EN1)
    begin
      rd_word = pick(rbank, ien_reg);
    end
    else
    begin
      rd_hit = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flops

  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign pin_out = out_val_reg;
  assign pin_oe = oe_reg;
  assign irq_bank0 = irq0_reg;
  assign irq_bank1 = irq1_reg;
  assign irq_any = irqa_reg;

endmodule : gpio_output_level_event_bank

// File: sim/gpio_bank_chk.sv
`timescale 1ns/1ps
module gpio_bank_chk (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic awvalid, // write address valid
  input wire logic awready, // write address ready
  input wire logic wvalid, // write data valid
  input wire logic wready, // write data ready
  input wire logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic arvalid, // read address valid
  input wire logic arready, // read address ready
  input wire logic rvalid, // read data valid
  input wire logic [57:0] pin_out, // latched drive values
  input wire logic [57:0] pin_oe, // output enables
  input wire logic irq_bank0, // bank 0 line
  input wire logic irq_bank1, // bank 1 line
  input wire logic irq_any // any-flag line
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // a register write answered now or one cycle ago
  sequence wr_recent;
    bvalid || $past(bvalid);
  endsequence
  sequence both_taken;
    awvalid && awready && wvalid && wready;
  endsequence

  ////////////////////////////////////////////////////////////////////
  a_irq_any_or: assert property (irq_any == (irq_bank0 || irq_bank1))
    else $error("any line disagrees with bank lines");
  a_reset_quiet: assert property ($rose(aresetn) |-> !irq_any && pin_oe == '0 && pin_out == '0)
    else $error("outputs not quiet after reset");
  a_oe_by_write: assert property ($changed(pin_oe) |-> wr_recent)
    else $error("output enable moved without a write");
  a_out_by_write: assert property ($changed(pin_out) |-> wr_recent)
    else $error("drive value moved without a write");
  a_flag_sticky: assert property ($fell(irq_any) |-> wr_recent)
    else $error("interrupt dropped without a write");
  a_write_answer: assert property (both_taken |=> !bvalid ##1 bvalid)
    else $error("write response not two cycles after request");
  a_ready_back: assert property ((bvalid && bready) |=> awready && wready)
    else $error("write readies not back after response");
  a_read_answer: assert property ((arvalid && arready) |=> rvalid)
    else $error("read data not one cycle after request");
endmodule : gpio_bank_chk

bind gpio_output_level_event_bank gpio_bank_chk u_chk (.aclk, .aresetn, .awvalid, .awready,
  .wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .pin_out, .pin_oe,
  .irq_bank0, .irq_bank1, .irq_any);

// File: sim/pin_pads.sv
`timescale 1ns/1ps
module pin_pads (
  input wire logic [57:0] pin_out, // values the block drives
  input wire logic [57:0] pin_oe, // pins the block drives
  input wire logic [57:0] ext_level, // levels from the outside world
  output logic [57:0] pin_in // level seen at each pad
);
  // a driven pad reads back its own value, the rest follow outside
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : pin_pads

// File: sim/tb.sv
`timescale 1ns/1ps
module tb;
  logic aclk;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b1;
  logic arvalid = 1'b0;
  logic rready = 1'b1;
  logic [57:0] ext_level = 58'h000_0000_0000_0000;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [57:0] pin_in, pin_out, pin_oe;
  logic irq_bank0, irq_bank1, irq_any;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;

  // 50 MHz system clock
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  gpio_output_level_event_bank dut (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .pin_in, .pin_out, .pin_oe, .irq_bank0, .irq_bank1,
    .irq_any);
  pin_pads pads (.pin_out, .pin_oe, .ext_level, .pin_in);

  ////////////////////////////////////////////////////////////////////
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask : chk_word

  task automatic chk_bit(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("BAD %s expected %b seen %b", what, exp, got);
      failures++;
    end
  endtask : chk_bit

  // bready stays high, so the response is taken at the edge it shows
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = gpio_bank_pkg::RESP_OKAY);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while (!(bvalid && bready));
    chk_word("write response", 32'(er), 32'(bresp));
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [1:0] er = gpio_bank_pkg::RESP_OKAY);
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (!(rvalid && rready));
    chk_word("read data", exp, rdata);
    chk_word("read response", 32'(er), 32'(rresp));
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask : idle

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(gpio_bank_pkg::STATUS0, 32'h0000_0000);
    rd(gpio_bank_pkg::STATUS1, 32'h0000_0000);
    rd(gpio_bank_pkg::RISE_EN0, 32'h0000_0000);
    rd(gpio_bank_pkg::FALL_EN0, 32'h0000_0000);
    rd(gpio_bank_pkg::DRIVE_HIGH0, 32'h0000_0000);
    wr(gpio_bank_pkg::RISE_EN1, 32'hffff_ffff);
    rd(gpio_bank_pkg::RISE_EN1, 32'h03ff_ffff);
    wr(gpio_bank_pkg::RISE_EN1, 32'h0000_0000);
    wr(8'hfc, 32'hffff_ffff, gpio_bank_pkg::RESP_SLVERR);
    rd(8'hfc, 32'h0000_0000, gpio_bank_pkg::RESP_SLVERR);
    wr(gpio_bank_pkg::LEVEL0, 32'hffff_ffff);
    rd(gpio_bank_pkg::LEVEL0, 32'h0000_0000);
    // pin 5 as output, then drive it high and low
    wr(gpio_bank_pkg::FSEL_FIRST, 32'h0000_8000);
    chk_bit("oe pin 5", 1'b1, pin_oe[5]);
    chk_bit("oe pin 4", 1'b0, pin_oe[4]);
    wr(gpio_bank_pkg::DRIVE_HIGH0, 32'h0000_0020);
    chk_bit("out pin 5", 1'b1, pin_out[5]);
    wr(gpio_bank_pkg::DRIVE_LOW0, 32'h0000_0000);
    chk_bit("out pin 5", 1'b1, pin_out[5]);
    rd(gpio_bank_pkg::LEVEL0, 32'h0000_0020);
    wr(gpio_bank_pkg::DRIVE_LOW0, 32'h0000_0020);
    chk_bit("out pin 5", 1'b0, pin_out[5]);
    // a drive on an input pin is latched at once and reaches the pad when the pin turns output
    wr(gpio_bank_pkg::DRIVE_HIGH1, 32'h0000_0100);
    chk_bit("oe pin 40", 1'b0, pin_oe[40]);
    wr(8'h10, 32'h0000_0001);
    chk_bit("out pin 40", 1'b1, pin_out[40]);
    chk_bit("oe pin 40", 1'b1, pin_oe[40]);
    // the pad only now drives; let it pass the two-flop synchroniser
    idle(2);
    rd(gpio_bank_pkg::LEVEL1, 32'h0000_0100);
    // rising edge on pin 2, masking and clearing
    wr(gpio_bank_pkg::RISE_EN0, 32'h0000_0004);
    ext_level[2] <= 1'b1;
    idle(6);
    chk_bit("irq bank 0", 1'b1, irq_bank0);
    chk_bit("irq bank 1", 1'b0, irq_bank1);
    rd(gpio_bank_pkg::STATUS0, 32'h0000_0004);
    wr(gpio_bank_pkg::STATUS0, 32'h0000_0000);
    rd(gpio_bank_pkg::STATUS0, 32'h0000_0004);
    wr(gpio_bank_pkg::IRQ_EN0, 32'h0000_0000);
    chk_bit("masked irq", 1'b0, irq_any);
    wr(gpio_bank_pkg::IRQ_EN0, 32'hffff_ffff);
    wr(gpio_bank_pkg::STATUS0, 32'h0000_0004);
    chk_bit("irq any", 1'b0, irq_any);
    ext_level[2] <= 1'b0;
    idle(6);
    rd(gpio_bank_pkg::STATUS0, 32'h0000_0000);
    // a one-cycle glitch never shows three samples 011
    ext_level[2] <= 1'b1;
    @(posedge aclk);
    ext_level[2] <= 1'b0;
    idle(6);
    rd(gpio_bank_pkg::STATUS0, 32'h0000_0000);
    wr(gpio_bank_pkg::FALL_EN0, 32'h0000_0004);
    ext_level[2] <= 1'b1;
    idle(6);
    rd(gpio_bank_pkg::STATUS0, 32'h0000_0004);
    wr(gpio_bank_pkg::STATUS0, 32'h0000_0004);
    ext_level[2] <= 1'b0;
    idle(6);
    rd(gpio_bank_pkg::STATUS0, 32'h0000_0004);
    wr(gpio_bank_pkg::STATUS0, 32'h0000_0004);
    // bank 1 edge raises only its own line
    wr(gpio_bank_pkg::RISE_EN1, 32'h0004_0000);
    ext_level[50] <= 1'b1;
    idle(6);
    chk_bit("irq bank 1", 1'b1, irq_bank1);
    chk_bit("irq bank 0", 1'b0, irq_bank0);
    rd(gpio_bank_pkg::STATUS1, 32'h0004_0000);
    wr(gpio_bank_pkg::IRQ_CLR1, 32'h0004_0000);
    rd(gpio_bank_pkg::STATUS1, 32'h0000_0000);
    // levels hold their flags against a clear
    ext_level[3] <= 1'b1;
    wr(gpio_bank_pkg::HIGH_EN0, 32'h0000_0008);
    wr(gpio_bank_pkg::STATUS0, 32'h0000_0008);
    rd(gpio_bank_pkg::STATUS0, 32'h0000_0008);
    wr(gpio_bank_pkg::HIGH_EN0, 32'h0000_0000);
    wr(gpio_bank_pkg::STATUS0, 32'h0000_0008);
    rd(gpio_bank_pkg::STATUS0, 32'h0000_0000);
    wr(gpio_bank_pkg::LOW_EN1, 32'h0000_0001);
    wr(gpio_bank_pkg::STATUS1, 32'h0000_0001);
    rd(gpio_bank_pkg::STATUS1, 32'h0000_0001);
    chk_bit("irq bank 1", 1'b1, irq_bank1);
    // second reset in mid-run
    aresetn <= 1'b0;
    idle(2);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(gpio_bank_pkg::STATUS1, 32'h0000_0000);
    chk_bit("oe pin 5", 1'b0, pin_oe[5]);
    report_and_stop();
  end
endmodule : tb
